// [hdl/dpcbx_pkg.sv]
// package for the cyclic buffer exchange block: offsets, fields, types
package dpcbx_pkg;

  // register addresses as word indices, compared directly with wb_adr_i
  localparam logic [7:0] IDX_IN_STATES   = 8'h08;
  localparam logic [7:0] IDX_IN_SWAP     = 8'h09;
  localparam logic [7:0] IDX_OUT_STATES  = 8'h0A;
  localparam logic [7:0] IDX_OUT_SWAP    = 8'h0B;
  localparam logic [7:0] IDX_CONTROL     = 8'h0C;
  localparam logic [7:0] IDX_RELOAD      = 8'h0D;
  localparam logic [7:0] IDX_STATUS      = 8'h0E;
  localparam logic [7:0] IDX_COUNTER     = 8'h0F;

  // control register bit positions
  localparam int CTL_SYNC_EN   = 0;
  localparam int CTL_FREEZE_EN = 1;
  localparam int CTL_REARM     = 2;
  localparam int CTL_GO_PRM    = 3;

  // field positions in the state cells
  localparam int FLD_D = 0;
  localparam int FLD_N = 2;
  localparam int FLD_U = 4;
  localparam int FLD_F = 6;

  // swap cell flags
  localparam int SWP_NEW_U   = 2;
  localparam int SWP_CLEARED = 3;

  // slot pointers; 2'h0 means none
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_ONE  = 2'h1;
  localparam logic [1:0] SLOT_TWO  = 2'h2;
  localparam logic [1:0] SLOT_THR  = 2'h3;

  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0]  CTL_RESET    = 8'h00;

  // link protocol states
  typedef enum logic [1:0] {
    DPCBX_WAIT_PRM,
    DPCBX_WAIT_CFG,
    DPCBX_CYCLIC_EXCHANGE_STATE
  } dpcbx_link_e;

  // one buffer set: pointers for the four states
  typedef struct packed {
    logic [1:0] f;
    logic [1:0] u;
    logic [1:0] n;
    logic [1:0] d;
  } dpcbx_ring_s;

  localparam dpcbx_ring_s RING_RESET = '{f: SLOT_NONE, u: SLOT_ONE,
                                         n: SLOT_TWO, d: SLOT_THR};

  // events from the fieldbus receive/transmit logic
  typedef struct packed {
    logic prm_ok;      // parameter telegram acknowledged
    logic cfg_ok;      // configuration telegram acknowledged
    logic out_done;    // output telegram received without error
    logic out_bad;     // output telegram received with error
    logic in_start;    // input transmission about to start
    logic gc_clear;    // global clear
    logic gc_sync;     // global sync or unsync
    logic gc_freeze;   // global freeze
    logic gc_unfreeze; // global unfreeze
    logic leave;       // master dropped by link layer
  } dpcbx_link_ev_s;

endpackage : dpcbx_pkg

// [hdl/dpcbx_core.sv]
// triple buffer manager and host-alive watchdog with wishbone registers
// Operation
// - output telegram fills D; only good reception moves D to N, raising irq
// - output swap read hands the N buffer to the host as U
// - output swap read with no new N buffer changes nothing
// - newer received output buffers replace the one waiting in N
// - power-on, drop, clear, await-params zero D then move it to N
// - host taking a zeroed buffer sees the cleared flag on swap read
// - output swap read returns index, new-U bit two, cleared bit three
// - sync mode defers output D-to-N until next sync or unsync
// - output state cell holds F, U, N, D two-bit pointer fields
// - input sent from D; N moves to D first when new, unless an input swap read comes in that cycle
// - input swap read moves host U buffer to N, latest wins
// - no new input buffer means same input data is resent
// - cyclic state only after prm and cfg acks; host then swaps
// - freeze mode skips the input N-to-D exchange before sending
// - input state cell holds F, U, N, D two-bit pointer fields
// - input swap read returns new host buffer index, upper bits zero
// - sixteen bit host-alive counter, reloaded, decremented per telegram
// - telegram taking counter from one to zero returns to await-params and drops the master
// - host sets rearm; next telegram reloads counter and clears rearm
// - read-outputs request sends the buffer currently in U
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps

module dpcbx_core (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // fieldbus side events
  input  wire dpcbx_pkg::dpcbx_link_ev_s link_ev,
  // buffer selection and status towards the data path
  output logic      [1:0]              out_write_slot,
  output logic      [1:0]              out_zero_slot,
  output logic      [1:0]              out_readback_slot,
  output logic      [1:0]              in_send_slot,
  output logic                         output_arrival_irq,
  output logic                         drop_master,
  output logic                         cyclic_exchange_state
);

  dpcbx_pkg::dpcbx_ring_s out_ring;
  dpcbx_pkg::dpcbx_ring_s in_ring;
  dpcbx_pkg::dpcbx_link_e link_state_machine;
  logic [7:0]  ctl;
  logic [15:0] host_alive_reload;
  logic [15:0] host_alive_counter;
  logic        n_fresh_out;
  logic        n_cleared;
  logic        u_cleared;
  logic        n_fresh_in;
  logic        clear_pend;
  logic        sync_pend;
  logic        frozen;
  logic        por_seen;
  logic        wd_expire;
  logic        rd_strobe;
  logic        wr_strobe;
  logic        out_swap_rd;
  logic        in_swap_rd;
  logic        zero_d;
  logic        out_commit;

  // assertions below share the system clock and reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // single cycle ack; it clears itself the next cycle even with stb held
  assign rd_strobe   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wr_strobe   = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign out_swap_rd = rd_strobe && wb_adr_i == dpcbx_pkg::IDX_OUT_SWAP;
  assign in_swap_rd  = rd_strobe && wb_adr_i == dpcbx_pkg::IDX_IN_SWAP;

  function automatic logic [7:0] pack_ring(dpcbx_pkg::dpcbx_ring_s r);
    pack_ring = {r.f, r.u, r.n, r.d};
  endfunction : pack_ring

  assign wd_expire = link_ev.out_done && !ctl[dpcbx_pkg::CTL_REARM]
                     && host_alive_counter == 16'h0001
                     && link_state_machine == dpcbx_pkg::DPCBX_CYCLIC_EXCHANGE_STATE;

  // zeroing D: por, drop, clear, entering await-params
  assign zero_d = clear_pend;

  // output commit: good rx and not held by sync
  assign out_commit = (link_ev.out_done && !ctl[dpcbx_pkg::CTL_SYNC_EN])
                      || (link_ev.gc_sync && sync_pend);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      por_seen <= 1'b0;
    end else begin
      por_seen <= 1'b1;
    end
  end

  // link state and clear request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_state_machine <= dpcbx_pkg::DPCBX_WAIT_PRM;
      clear_pend         <= 1'b0;
    end else begin
      clear_pend <= !por_seen || link_ev.leave || wd_expire
                    || link_ev.gc_clear
                    || (wr_strobe && wb_adr_i == dpcbx_pkg::IDX_CONTROL
                        && wb_sel_i[0] && wb_dat_i[dpcbx_pkg::CTL_GO_PRM]);
      if (wd_expire || link_ev.leave || (wr_strobe
          && wb_adr_i == dpcbx_pkg::IDX_CONTROL && wb_sel_i[0]
          && wb_dat_i[dpcbx_pkg::CTL_GO_PRM])) begin
        link_state_machine <= dpcbx_pkg::DPCBX_WAIT_PRM;
      end else begin
        case (link_state_machine)
          dpcbx_pkg::DPCBX_WAIT_PRM:
            if (link_ev.prm_ok) begin
              link_state_machine <= dpcbx_pkg::DPCBX_WAIT_CFG;
            end
          dpcbx_pkg::DPCBX_WAIT_CFG:
            if (link_ev.cfg_ok) begin
              link_state_machine <= dpcbx_pkg::DPCBX_CYCLIC_EXCHANGE_STATE;
            end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drop_master <= 1'b0;
    end else begin
      drop_master <= wd_expire;
    end
  end

  // output ring: hardware swaps D/N, host swaps N/U
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_ring    <= dpcbx_pkg::RING_RESET;
      n_fresh_out <= 1'b0;
      n_cleared   <= 1'b0;
      u_cleared   <= 1'b0;
    end else begin
      if (out_swap_rd && n_fresh_out && (zero_d || out_commit)) begin
        // host swap and D commit together rotate all three, none lost
        out_ring.u  <= out_ring.n;
        out_ring.n  <= out_ring.d;
        out_ring.d  <= out_ring.u;
        u_cleared   <= n_cleared;
        n_cleared   <= zero_d;
      end else if (out_swap_rd && n_fresh_out) begin
        out_ring.u  <= out_ring.n;
        out_ring.n  <= out_ring.u;
        n_fresh_out <= 1'b0;
        u_cleared   <= n_cleared;
      end else if (zero_d || out_commit) begin
        out_ring.n  <= out_ring.d;
        out_ring.d  <= out_ring.n;
        n_fresh_out <= 1'b1;
        n_cleared   <= zero_d;
      end
    end
  end

  // sync holds a filled D until the next sync or unsync command
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_pend <= 1'b0;
    end else if (link_ev.out_done && ctl[dpcbx_pkg::CTL_SYNC_EN]) begin
      sync_pend <= 1'b1;
    end else if (link_ev.gc_sync || !ctl[dpcbx_pkg::CTL_SYNC_EN]) begin
      sync_pend <= 1'b0;
    end
  end

  // input ring: host swaps U/N, hardware swaps N/D before sending
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_ring    <= dpcbx_pkg::RING_RESET;
      n_fresh_in <= 1'b0;
    end else begin
      if (in_swap_rd) begin
        in_ring.n  <= in_ring.u;
        in_ring.u  <= in_ring.n;
        n_fresh_in <= 1'b1;
      end else if (link_ev.in_start && n_fresh_in
                   && !(ctl[dpcbx_pkg::CTL_FREEZE_EN] && frozen)) begin
        in_ring.d  <= in_ring.n;
        in_ring.n  <= in_ring.d;
        n_fresh_in <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      frozen <= 1'b0;
    end else if (link_ev.gc_unfreeze) begin
      frozen <= 1'b0;
    end else if (link_ev.in_start && ctl[dpcbx_pkg::CTL_FREEZE_EN]
                 && link_ev.gc_freeze) begin
      frozen <= 1'b1;
    end else if (link_ev.gc_freeze) begin
      frozen <= 1'b1;
    end
  end

  // control register; rearm cleared by next telegram, host set wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= dpcbx_pkg::CTL_RESET;
    end else if (wr_strobe && wb_adr_i == dpcbx_pkg::IDX_CONTROL
                 && wb_sel_i[0]) begin
      ctl <= {4'h0, 1'b0, wb_dat_i[2:0]};
    end else if (link_ev.out_done) begin
      ctl[dpcbx_pkg::CTL_REARM] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_alive_reload <= dpcbx_pkg::RELOAD_RESET;
    end else if (wr_strobe && wb_adr_i == dpcbx_pkg::IDX_RELOAD) begin
      if (wb_sel_i[0]) begin
        host_alive_reload[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        host_alive_reload[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_alive_counter <= 16'h0000;
    end else if (link_ev.out_done) begin
      if (ctl[dpcbx_pkg::CTL_REARM]) begin
        host_alive_counter <= host_alive_reload;
      end else if (host_alive_counter != 16'h0000) begin
        host_alive_counter <= host_alive_counter - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      output_arrival_irq <= 1'b0;
    end else begin
      output_arrival_irq <= link_ev.out_done;
    end
  end

  // read data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_strobe) begin
      if (wb_adr_i == dpcbx_pkg::IDX_IN_STATES) begin
        wb_dat_o <= {24'h0, pack_ring(in_ring)};
      end else if (wb_adr_i == dpcbx_pkg::IDX_IN_SWAP) begin
        wb_dat_o <= {30'h0, in_ring.n};
      end else if (wb_adr_i == dpcbx_pkg::IDX_OUT_STATES) begin
        wb_dat_o <= {24'h0, pack_ring(out_ring)};
      end else if (wb_adr_i == dpcbx_pkg::IDX_OUT_SWAP) begin
        wb_dat_o <= {28'h0, n_fresh_out ? n_cleared : u_cleared,
                     n_fresh_out,
                     n_fresh_out ? out_ring.n : out_ring.u};
      end else if (wb_adr_i == dpcbx_pkg::IDX_CONTROL) begin
        wb_dat_o <= {24'h0, ctl};
      end else if (wb_adr_i == dpcbx_pkg::IDX_RELOAD) begin
        wb_dat_o <= {16'h0, host_alive_reload};
      end else if (wb_adr_i == dpcbx_pkg::IDX_STATUS) begin
        wb_dat_o <= {28'h0, frozen, sync_pend,
                     link_state_machine};
      end else if (wb_adr_i == dpcbx_pkg::IDX_COUNTER) begin
        wb_dat_o <= {16'h0, host_alive_counter};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  assign out_write_slot        = out_ring.d;
  assign out_zero_slot         = zero_d ? out_ring.d : dpcbx_pkg::SLOT_NONE;
  assign out_readback_slot     = out_ring.u;
  assign in_send_slot          = in_ring.d;
  assign cyclic_exchange_state =
    link_state_machine == dpcbx_pkg::DPCBX_CYCLIC_EXCHANGE_STATE;

  AST_OUT_SWAP: assert property (
    out_swap_rd && n_fresh_out |=> out_ring.u == $past(out_ring.n))
    else $error("output swap did not hand N to host");
  AST_NO_SWAP: assert property (
    out_swap_rd && !n_fresh_out |=> $stable(out_ring.u))
    else $error("output swap moved without new buffer");
  AST_COMMIT: assert property (
    link_ev.out_done && !ctl[dpcbx_pkg::CTL_SYNC_EN]
    |=> out_ring.n == $past(out_ring.d) && n_fresh_out)
    else $error("good output telegram not committed to N");
  AST_SYNC_HOLD: assert property (
    link_ev.out_done && ctl[dpcbx_pkg::CTL_SYNC_EN] && !zero_d
    && !out_swap_rd && !link_ev.gc_sync |=> $stable(out_ring.n))
    else $error("sync mode let output D reach N");
  AST_BAD_RX: assert property (
    link_ev.out_bad && !link_ev.out_done && !zero_d && !out_swap_rd
    && !link_ev.gc_sync |=> $stable(out_ring) && !output_arrival_irq)
    else $error("bad output telegram changed the ring");
  AST_ZERO: assert property (
    zero_d |=> out_ring.n == $past(out_ring.d) && n_cleared && n_fresh_out)
    else $error("zeroed D buffer not handed to N");
  AST_OUT_FLAGS: assert property (
    out_swap_rd && n_fresh_out |=> wb_dat_o[dpcbx_pkg::SWP_NEW_U]
    && wb_dat_o[dpcbx_pkg::SWP_CLEARED] == $past(n_cleared))
    else $error("output swap flags wrong");
  AST_IRQ: assert property (
    link_ev.out_done |=> output_arrival_irq)
    else $error("arrival irq missing");
  AST_IN_SWAP: assert property (
    in_swap_rd |=> in_ring.n == $past(in_ring.u) && n_fresh_in)
    else $error("input swap did not move U to N");
  AST_IN_IDX: assert property (
    in_swap_rd |=> wb_dat_o == {30'h0, $past(in_ring.n)})
    else $error("input swap returned wrong index");
  AST_IN_SEND: assert property (
    link_ev.in_start && n_fresh_in && !frozen && !in_swap_rd
    |=> in_ring.d == $past(in_ring.n))
    else $error("new input buffer not moved to D");
  AST_FREEZE: assert property (
    link_ev.in_start && frozen && ctl[dpcbx_pkg::CTL_FREEZE_EN]
    && !in_swap_rd |=> $stable(in_ring.d))
    else $error("frozen input buffer changed");
  AST_REARM: assert property (
    link_ev.out_done && ctl[dpcbx_pkg::CTL_REARM] && !wr_strobe
    |=> host_alive_counter == $past(host_alive_reload)
    && !ctl[dpcbx_pkg::CTL_REARM])
    else $error("rearm did not reload counter");
  AST_EXPIRE: assert property (
    wd_expire |=> drop_master && !cyclic_exchange_state)
    else $error("watchdog expiry did not drop master");
  AST_DISTINCT: assert property (
    out_ring.u != out_ring.n && out_ring.n != out_ring.d
    && out_ring.u != out_ring.d)
    else $error("output buffer in two states");
  AST_IN_DISTINCT: assert property (
    in_ring.u != in_ring.n && in_ring.n != in_ring.d
    && in_ring.u != in_ring.d)
    else $error("input buffer in two states");
  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  COV_SWAP: cover property (@(posedge clk_sys) out_swap_rd && n_fresh_out);
  COV_EXPIRE: cover property (@(posedge clk_sys) wd_expire);
  COV_INSEND: cover property (@(posedge clk_sys)
    link_ev.in_start && n_fresh_in);
  COV_SYNC: cover property (@(posedge clk_sys)
    link_ev.gc_sync && sync_pend);
  COV_CLEAR: cover property (@(posedge clk_sys) zero_d && por_seen);

endmodule : dpcbx_core

// [dv/dpcbx_master_model.sv]
// fieldbus master stand-in: turns bench requests into one-cycle events
`timescale 1ns/100ps

module dpcbx_master_model (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // bench request: kind 0 is prm_ok up to 9 for leave
  input  wire logic                 kick,
  input  wire logic [3:0]           kind,
  // events towards the block
  output dpcbx_pkg::dpcbx_link_ev_s link_ev
);
  logic prm_seen;

  // a real master never acks config before params went through
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_ev  <= '0;
      prm_seen <= 1'b0;
    end else begin
      if (kick && (kind != 4'h1 || prm_seen)) begin
        link_ev <= dpcbx_pkg::dpcbx_link_ev_s'(10'h200 >> kind);
      end else begin
        link_ev <= '0;
      end
      if (kick && kind == 4'h0) begin
        prm_seen <= 1'b1;
      end
    end
  end
endmodule : dpcbx_master_model

// [dv/tb_dpcbx_core.sv]
// self-checking bench: scoreboard of both buffer rings and the watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_dpcbx_core;
  logic                      clk_sys = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      wb_cyc = 1'b0;
  logic                      wb_stb = 1'b0;
  logic                      wb_we = 1'b0;
  logic [7:0]                wb_adr = 8'h00;
  logic [3:0]                wb_sel = 4'h0;
  logic [31:0]               wb_wdat = 32'h0;
  logic [31:0]               wb_rdat;
  logic                      wb_ack;
  logic                      kick = 1'b0;
  logic [3:0]                kind = 4'h0;
  dpcbx_pkg::dpcbx_link_ev_s link_ev;
  logic [1:0]                ows, ozs, ors, iss, oz_s;
  logic                      irq, drop, cyc_st, irq_s;
  logic [31:0]               q;
  logic [15:0]               rl;
  dpcbx_pkg::dpcbx_ring_s    om, im;
  bit                        onew, ncl, inew, pend, syn, frz, ucl;
  int                        k;
  int                        n_errors = 0;
  int                        compares = 0;

  always #10 clk_sys = ~clk_sys;

  dpcbx_core u_dpcbx_core (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_ev(link_ev),
    .out_write_slot(ows), .out_zero_slot(ozs), .out_readback_slot(ors),
    .in_send_slot(iss), .output_arrival_irq(irq), .drop_master(drop),
    .cyclic_exchange_state(cyc_st));

  dpcbx_master_model u_dpcbx_master_model (.clk_sys(clk_sys),
    .reset_n(reset_n), .kick(kick), .kind(kind), .link_ev(link_ev));

  task automatic conclude;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // classic cycle, entered right after a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    wb_sel  <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_rdat;
    if (wb_ack !== 1'b1) begin
      n_errors++;
      conclude();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0, q);
    `CHK(q, {24'h0, e})
  endtask : rd

  // event reaches the block one edge after the kick; the block acts on it at the next edge
  task automatic ev(input logic [3:0] t);
    kick <= 1'b1;
    kind <= t;
    @(posedge clk_sys);
    kick <= 1'b0;
    @(posedge clk_sys);
    #1;
    irq_s = irq;
    oz_s  = ozs;
    @(posedge clk_sys);
  endtask : ev

  task automatic cells;
    rd(8'h08, im);
    rd(8'h0A, om);
    `CHK(iss, im.d)
    `CHK(ors, om.u)
    `CHK(ows, om.d)
  endtask : cells

  task automatic do_out;
    ev(4'h2);
    cnt_step();
    `CHK(oz_s, dpcbx_pkg::SLOT_NONE)
    if (syn) begin
      pend = 1'b1;
    end else begin
      {om.d, om.n} = {om.n, om.d};
      onew = 1'b1;
      ncl  = 1'b0;
      `CHK(irq_s, 1'b1)
    end
  endtask : do_out

  task automatic cnt_step;
    rl = rl - 16'h0001;
  endtask : cnt_step

  task automatic do_in;
    ev(4'h4);
    if (inew && !frz) begin
      {im.n, im.d} = {im.d, im.n};
      inew = 1'b0;
    end
  endtask : do_in

  task automatic do_osw;
    logic [7:0] e;
    e = {4'h0, ucl, 1'b0, om.u};
    if (onew) begin
      {om.u, om.n} = {om.n, om.u};
      e = {4'h0, ncl, 1'b1, om.u};
      ucl  = ncl;
      onew = 1'b0;
    end
    rd(8'h0B, e);
  endtask : do_osw

  task automatic do_isw;
    {im.u, im.n} = {im.n, im.u};
    inew = 1'b1;
    rd(8'h09, {6'h0, im.u});
  endtask : do_isw

  initial begin
    void'($urandom(63));
    om = dpcbx_pkg::RING_RESET;
    {om.d, om.n} = {om.n, om.d};
    onew = 1'b1;
    ncl  = 1'b1;
    im   = dpcbx_pkg::RING_RESET;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // read-only cell and a hole in the map
    wb(1'b1, 8'h0A, 32'h0, q);
    cells();
    rd(8'h20, 8'h00);
    // host start-up: reload value, then rearm before exchange
    rl = 16'(16'h0080 + $urandom_range(16'hFF00));
    wb(1'b1, 8'h0D, {16'h0, rl}, q);
    wb(1'b1, 8'h0C, 32'h4, q);
    ev(4'h0);
    `CHK(cyc_st, 1'b0)
    cells();
    ev(4'h1);
    `CHK(cyc_st, 1'b1)
    do_osw();
    do_out();
    rl = rl + 16'h0001;
    rd(8'h0C, 8'h00);
    wb(1'b0, 8'h0F, 32'h0, q);
    `CHK(q, {16'h0, rl})
    do_isw();
    repeat (40) begin
      case ($urandom % 4)
        0: do_out();
        1: do_in();
        2: do_osw();
        default: do_isw();
      endcase
      cells();
    end
    wb(1'b0, 8'h0F, 32'h0, q);
    `CHK(q[15:0], rl)
    // sync: D fills but waits for the sync command
    wb(1'b1, 8'h0C, 32'h1, q);
    syn = 1'b1;
    do_out();
    do_out();
    cells();
    ev(4'h6);
    {om.d, om.n} = {om.n, om.d};
    onew = 1'b1;
    ncl  = 1'b0;
    syn  = 1'b0;
    cells();
    do_osw();
    // freeze: no input exchange before sending
    wb(1'b1, 8'h0C, 32'h2, q);
    do_in();
    ev(4'h7);
    frz = 1'b1;
    do_isw();
    do_in();
    cells();
    ev(4'h8);
    frz = 1'b0;
    do_in();
    do_in();
    cells();
    // errored output telegram leaves every buffer where it was
    ev(4'h3);
    `CHK(irq_s, 1'b0)
    cells();
    // global clear zeroes D and hands it to N
    ev(4'h5);
    `CHK(oz_s, om.d)
    {om.d, om.n} = {om.n, om.d};
    onew = 1'b1;
    ncl  = 1'b1;
    cells();
    do_osw();
    // watchdog: reload of two runs out on the third telegram
    wb(1'b1, 8'h0D, 32'h2, q);
    wb(1'b1, 8'h0C, 32'h4, q);
    do_out();
    do_out();
    kick <= 1'b1;
    kind <= 4'h2;
    @(posedge clk_sys);
    kick <= 1'b0;
    k = 0;
    while (drop !== 1'b1 && k < 12) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(k < 12, 1'b1)
    repeat (3) @(posedge clk_sys);
    `CHK(cyc_st, 1'b0)
    rd(8'h0E, 8'h00);
    // commit then zero swap leave the slots in place, N fresh and cleared
    onew = 1'b1;
    ncl  = 1'b1;
    cells();
    do_osw();
    // host forces await-params, then the master leaves
    wb(1'b1, 8'h0C, 32'h8, q);
    {om.d, om.n} = {om.n, om.d};
    onew = 1'b1;
    cells();
    ev(4'h9);
    `CHK(oz_s, om.d)
    {om.d, om.n} = {om.n, om.d};
    cells();
    do_osw();
    conclude();
  end
endmodule : tb_dpcbx_core
